// ### design/luma_gain_pkg.sv
// Constants, types and field layout of the luma gain and hsync position register bank.
// Assumes an 8-bit register port and a pixel-rate clock shared with the video datapath.
package luma_gain_pkg;

  // Register offsets.
  localparam logic [7:0] OFS_MAN_GAIN_LO = 8'h30;
  localparam logic [7:0] OFS_SHADOW_HI = 8'h31;
  localparam logic [7:0] OFS_SHADOW_LO = 8'h32;
  localparam logic [7:0] OFS_MISC = 8'h33;
  localparam logic [7:0] OFS_HS_HI = 8'h34;
  localparam logic [7:0] OFS_HS_BEGIN_LO = 8'h35;
  localparam logic [7:0] OFS_HS_END_LO = 8'h36;

  // Field positions.
  localparam int SURV_EN_BIT = 7;
  localparam int PW_RATE_BIT = 0;
  localparam int AVG_RANGE_BIT = 1;
  localparam int IRE_LSB = 2;
  localparam int CKILL_BIT = 6;
  localparam int HS_END_HI_LSB = 4;
  localparam int HS_BEGIN_HI_LSB = 6;

  // Bits that always read as one.
  localparam logic [7:0] SHADOW_HI_RSVD = 8'h70;
  localparam logic [7:0] MISC_RSVD = 8'hA0;
  localparam logic [7:0] HS_HI_RSVD = 8'h0F;

  // Reset values.
  localparam logic [7:0] RST_GAIN_BYTE = 8'h00;
  localparam logic [3:0] RST_GAIN_NIB = 4'h0;
  localparam logic [7:0] RST_MISC = 8'h00;
  localparam logic [1:0] RST_HS_HI = 2'h0;
  localparam logic [7:0] RST_HS_BEGIN_LO = 8'h01;
  localparam logic [7:0] RST_HS_END_LO = 8'h00;
  localparam logic [7:0] RD_UNMAPPED = 8'h00;

  // Average brightness line window.
  localparam logic [8:0] AVG_FIRST_LINE = 9'h021;
  localparam logic [8:0] AVG_LAST_FULL = 9'h136;
  localparam logic [8:0] AVG_LAST_SHORT = 9'h10E;

  // Luma gain modes of the neighbouring mode register.
  typedef enum logic [2:0] {
    MODE_MANUAL = 3'b000,
    MODE_NO_OVR_A = 3'b001,
    MODE_AUTO = 3'b010,
    MODE_NO_OVR_B = 3'b011,
    MODE_AUTO_OVR = 3'b100,
    MODE_PEAK_WHITE = 3'b101,
    MODE_AVG_VIDEO = 3'b110,
    MODE_FREEZE = 3'b111
  } gain_mode_t;

  // Decoded gain-control settings handed to the luma datapath.
  typedef struct packed {
    logic update_per_field;
    logic avg_short_range;
    logic [2:0] ire_code;
    logic colour_kill_en;
  } gain_ctrl_t;

endpackage

// ### design/hsync_pulse_gen.sv
// Programmable hsync output pulse, timed in pixels from the internal hsync falling edge.
// Assumes begin and end positions are stable between line boundaries.
`timescale 1ns/10ps
module hsync_pulse_gen
  import luma_gain_pkg::*;
(
  // Clock and reset.
  input wire logic core_clk,
  input wire logic rst,
  // Line timing.
  input wire logic hsync_fall,
  input wire logic [9:0] begin_pos,
  input wire logic [9:0] end_pos,
  // Pulse.
  output logic hsync_out
);

  logic [9:0] pix_q;
  logic run_q;

  // Pixel count since the last falling edge; it stops rather than wraps on long lines.
  always_ff @(posedge core_clk) begin
    if (rst) begin
      pix_q <= 10'h000;
      run_q <= 1'b0;
    end else if (hsync_fall) begin
      pix_q <= 10'h000;
      run_q <= 1'b1;
    end else if (run_q && pix_q != 10'h3FF) begin
      pix_q <= pix_q + 10'h001;
    end
  end

  // Set at the begin count and cleared at the end count; end wins if both match.
  always_ff @(posedge core_clk) begin
    if (rst) begin
      hsync_out <= 1'b0;
    end else if (run_q && !hsync_fall && pix_q == end_pos) begin
      hsync_out <= 1'b0;
    end else if (run_q && !hsync_fall && pix_q == begin_pos) begin
      hsync_out <= 1'b1;
    end
  end

endmodule

// ### design/luma_gain_hsync_position_regs.sv
// Register bank for luma manual gain, the gain shadow store, miscellaneous gain
// control and hsync output position. Assumes the mode and tracking fields, the
// manual gain upper nibble, the automatic gain and line timing come from logic
// on the same clock.
// Every input is synchronous to core_clk, so none of them passes a synchroniser here.
//
// Design decision made here: the strobed register port.
`timescale 1ns/10ps
module luma_gain_hsync_position_regs
  import luma_gain_pkg::*;
(
  // Clock and reset.
  input wire logic core_clk,
  input wire logic rst,
  // Register port.
  input wire logic [7:0] addr,
  input wire logic [7:0] wr_data,
  input wire logic wr_en,
  input wire logic rd_en,
  output logic [7:0] rd_data,
  // Neighbouring control fields.
  input wire logic [2:0] luma_gain_mode_select,
  input wire logic [1:0] luma_gain_tracking_speed,
  input wire logic [3:0] luma_manual_gain_high,
  // Luma datapath status.
  input wire logic [11:0] auto_gain,
  input wire logic is_pal,
  // Line timing.
  input wire logic hsync_int,
  input wire logic field_start,
  input wire logic [8:0] line_num,
  // Gain outputs.
  output logic [11:0] applied_gain,
  output logic [1:0] tracking_speed,
  output logic tracking_active,
  output logic gain_update,
  output gain_ctrl_t gain_ctrl,
  output logic [7:0] max_ire_level,
  output logic avg_window,
  // Hsync output.
  output logic hsync_out
);

  // Software-visible storage.
  logic [7:0] man_gain_lo_q;
  logic [3:0] shadow_hi_q;
  logic [7:0] shadow_lo_q;
  logic surv_en_q;
  gain_ctrl_t misc_q;
  logic [1:0] hs_end_hi_q;
  logic [1:0] hs_begin_hi_q;
  logic [7:0] hs_begin_lo_q;
  logic [7:0] hs_end_lo_q;

  // Values in use by the datapath, refreshed at line boundaries.
  logic [11:0] man_gain_use_q;
  logic [11:0] shadow_use_q;
  logic surv_use_q;
  logic [9:0] hs_begin_use_q;
  logic [9:0] hs_end_use_q;

  // Line boundary detection and the decoded gain mode.
  logic hsync_int_q;
  logic line_start;
  gain_mode_t mode;

  // Mode decode and the falling-edge line boundary.
  assign mode = gain_mode_t'(luma_gain_mode_select);
  assign line_start = hsync_int_q && !hsync_int;

  // Peak-white and average-video modes are the ones that measure active video.
  function automatic logic measures_video(input gain_mode_t m);
    measures_video = (m == MODE_PEAK_WHITE) || (m == MODE_AVG_VIDEO);
  endfunction

  // Manual fixed gain is the one mode in which the shadow store is shown and applied.
  function automatic logic is_manual(input gain_mode_t m);
    is_manual = (m == MODE_MANUAL);
  endfunction

  // Maximum input IRE for a code and standard.
  // Codes above 101 saturate at 100 for both standards.
  function automatic logic [7:0] ire_of(input logic [2:0] code, input logic pal);
    logic [7:0] p;
    logic [7:0] n;
    p = 8'h64;
    n = 8'h64;
    case (code)
      3'b000: begin
        p = 8'h85;
        n = 8'h7A;
      end
      3'b001: begin
        p = 8'h7D;
        n = 8'h73;
      end
      3'b010: begin
        p = 8'h78;
        n = 8'h6E;
      end
      3'b011: begin
        p = 8'h73;
        n = 8'h69;
      end
      3'b100: begin
        p = 8'h6E;
        n = 8'h64;
      end
      3'b101: begin
        p = 8'h69;
        n = 8'h64;
      end
      default: begin
        p = 8'h64;
        n = 8'h64;
      end
    endcase
    ire_of = pal ? p : n;
  endfunction

  // Edge detector on the internal hsync, which marks the line boundary.
  // History resets low, so a line already low at reset gives no false boundary.
  always_ff @(posedge core_clk) begin
    if (rst) begin
      hsync_int_q <= 1'b0;
    end else begin
      hsync_int_q <= hsync_int;
    end
  end

  // Gain bytes written by software.
  // Reserved bits of the shadow control byte are dropped here and read back as one.
  always_ff @(posedge core_clk) begin
    if (rst) begin
      man_gain_lo_q <= RST_GAIN_BYTE;
      shadow_hi_q <= RST_GAIN_NIB;
      shadow_lo_q <= RST_GAIN_BYTE;
      surv_en_q <= 1'b0;
    end else if (wr_en) begin
      if (addr == OFS_MAN_GAIN_LO) begin
        man_gain_lo_q <= wr_data;
      end else if (addr == OFS_SHADOW_HI) begin
        shadow_hi_q <= wr_data[3:0];
        surv_en_q <= wr_data[SURV_EN_BIT];
      end else if (addr == OFS_SHADOW_LO) begin
        shadow_lo_q <= wr_data;
      end
    end
  end

  // Miscellaneous gain control; reserved bits are not stored.
  // The rate, range, level and kill fields reach the datapath one cycle later.
  always_ff @(posedge core_clk) begin
    if (rst) begin
      misc_q <= gain_ctrl_t'(RST_MISC[5:0]);
    end else if (wr_en && addr == OFS_MISC) begin
      misc_q.update_per_field <= wr_data[PW_RATE_BIT];
      misc_q.avg_short_range <= wr_data[AVG_RANGE_BIT];
      misc_q.ire_code <= wr_data[IRE_LSB +: 3];
      misc_q.colour_kill_en <= wr_data[CKILL_BIT];
    end
  end

  // Hsync position bytes.
  // Both high pairs share one byte, so a single write moves begin and end together.
  always_ff @(posedge core_clk) begin
    if (rst) begin
      hs_end_hi_q <= RST_HS_HI;
      hs_begin_hi_q <= RST_HS_HI;
      hs_begin_lo_q <= RST_HS_BEGIN_LO;
      hs_end_lo_q <= RST_HS_END_LO;
    end else if (wr_en) begin
      if (addr == OFS_HS_HI) begin
        hs_end_hi_q <= wr_data[HS_END_HI_LSB +: 2];
        hs_begin_hi_q <= wr_data[HS_BEGIN_HI_LSB +: 2];
      end else if (addr == OFS_HS_BEGIN_LO) begin
        hs_begin_lo_q <= wr_data;
      end else if (addr == OFS_HS_END_LO) begin
        hs_end_lo_q <= wr_data;
      end
    end
  end

  // Split fields are joined and taken over only at the line boundary, so the
  // datapath never runs on a half-written pair. The cost is up to one line of lag.
  // A write in the boundary cycle itself waits for the following line.
  always_ff @(posedge core_clk) begin
    if (rst) begin
      man_gain_use_q <= {RST_GAIN_NIB, RST_GAIN_BYTE};
      shadow_use_q <= {RST_GAIN_NIB, RST_GAIN_BYTE};
      surv_use_q <= 1'b0;
      hs_begin_use_q <= {RST_HS_HI, RST_HS_BEGIN_LO};
      hs_end_use_q <= {RST_HS_HI, RST_HS_END_LO};
    end else if (line_start) begin
      man_gain_use_q <= {luma_manual_gain_high, man_gain_lo_q};
      shadow_use_q <= {shadow_hi_q, shadow_lo_q};
      surv_use_q <= surv_en_q;
      hs_begin_use_q <= {hs_begin_hi_q, hs_begin_lo_q};
      hs_end_use_q <= {hs_end_hi_q, hs_end_lo_q};
    end
  end

  // Applied gain: manual mode uses the fixed value, with the shadow store in its
  // place when surveillance updates are on; freeze holds; all else follows the AGC.
  // Entering freeze keeps whatever the previous mode produced last.
  always_ff @(posedge core_clk) begin
    if (rst) begin
      applied_gain <= {RST_GAIN_NIB, RST_GAIN_BYTE};
    end else begin
      case (mode)
        MODE_MANUAL: begin
          applied_gain <= surv_use_q ? shadow_use_q : man_gain_use_q;
        end
        MODE_FREEZE: begin
          applied_gain <= applied_gain;
        end
        default: begin
          applied_gain <= auto_gain;
        end
      endcase
    end
  end

  // Tracking speed reaches the AGC only in automatic mode.
  // Zero is driven elsewhere so that a stale speed code never reaches the AGC.
  always_ff @(posedge core_clk) begin
    if (rst) begin
      tracking_speed <= 2'b00;
      tracking_active <= 1'b0;
    end else begin
      tracking_active <= (mode == MODE_AUTO);
      tracking_speed <= (mode == MODE_AUTO) ? luma_gain_tracking_speed : 2'b00;
    end
  end

  // Recalculation strobe for the measuring modes, per line or per field.
  // Only the selected boundary counts; the other one is ignored.
  always_ff @(posedge core_clk) begin
    if (rst) begin
      gain_update <= 1'b0;
    end else begin
      gain_update <= measures_video(mode) &&
                     (misc_q.update_per_field ? field_start : line_start);
    end
  end

  // Decoded control and measurement window for the luma datapath.
  // The level table is looked up after the field register, one cycle behind it.
  always_ff @(posedge core_clk) begin
    if (rst) begin
      gain_ctrl <= gain_ctrl_t'(RST_MISC[5:0]);
      max_ire_level <= 8'h00;
      avg_window <= 1'b0;
    end else begin
      gain_ctrl <= misc_q;
      max_ire_level <= ire_of(misc_q.ire_code, is_pal);
      avg_window <= measures_video(mode) && line_num >= AVG_FIRST_LINE &&
                    line_num <= (misc_q.avg_short_range ? AVG_LAST_SHORT
                                                        : AVG_LAST_FULL);
    end
  end

  // Read data one cycle after the strobe; the manual gain byte, and the shadow bytes outside manual mode, read back the gain in use.
  // Read data holds between reads, so a late look still sees the last result.
  always_ff @(posedge core_clk) begin
    if (rst) begin
      rd_data <= RD_UNMAPPED;
    end else if (rd_en) begin
      if (addr == OFS_MAN_GAIN_LO) begin
        rd_data <= applied_gain[7:0];
      end else if (addr == OFS_SHADOW_HI) begin
        rd_data <= {surv_en_q, 3'b000, is_manual(mode) ? shadow_hi_q
                    : applied_gain[11:8]} | SHADOW_HI_RSVD;
      end else if (addr == OFS_SHADOW_LO) begin
        rd_data <= is_manual(mode) ? shadow_lo_q : applied_gain[7:0];
      end else if (addr == OFS_MISC) begin
        rd_data <= {1'b0, misc_q.colour_kill_en, 1'b0, misc_q.ire_code,
                    misc_q.avg_short_range, misc_q.update_per_field} | MISC_RSVD;
      end else if (addr == OFS_HS_HI) begin
        rd_data <= {hs_begin_hi_q, hs_end_hi_q, 4'h0} | HS_HI_RSVD;
      end else if (addr == OFS_HS_BEGIN_LO) begin
        rd_data <= hs_begin_lo_q;
      end else if (addr == OFS_HS_END_LO) begin
        rd_data <= hs_end_lo_q;
      end else begin
        rd_data <= RD_UNMAPPED;
      end
    end
  end

  // Pulse position and length both come from the begin and end pair.
  // Its pixel counter restarts at every boundary seen by the edge detector.
  hsync_pulse_gen u_hsync (
    .core_clk(core_clk),
    .rst(rst),
    .hsync_fall(line_start),
    .begin_pos(hs_begin_use_q),
    .end_pos(hs_end_use_q),
    .hsync_out(hsync_out)
  );

endmodule

// ### test/luma_gain_chk.sv
// Concurrent checks on the luma gain and hsync register bank ports.
// Assumes one core_clk domain and a synchronous, active-high rst.
`timescale 1ns/10ps
module luma_gain_chk
  import luma_gain_pkg::*;
(
  // Clock and reset.
  input wire logic core_clk,
  input wire logic rst,
  // Register port.
  input wire logic [7:0] addr,
  input wire logic rd_en,
  input wire logic [7:0] rd_data,
  // Gain inputs.
  input wire logic [2:0] luma_gain_mode_select,
  input wire logic [1:0] luma_gain_tracking_speed,
  input wire logic [11:0] auto_gain,
  input wire logic is_pal,
  input wire logic [8:0] line_num,
  // Gain outputs.
  input wire logic [11:0] applied_gain,
  input wire logic [1:0] tracking_speed,
  input wire logic gain_update,
  input wire gain_ctrl_t gain_ctrl,
  input wire logic [7:0] max_ire_level,
  input wire logic avg_window
);
  logic [7:0] gain_lo;

  // The low byte is split off so that the history function sees a plain signal.
  assign gain_lo = applied_gain[7:0];

  // Ceiling per code; the top codes saturate at 100 for both standards.
  function automatic logic [7:0] ire_ref(input logic [2:0] c, input logic p);
    case (c)
      3'h0: return p ? 8'h85 : 8'h7A;
      3'h1: return p ? 8'h7D : 8'h73;
      3'h2: return p ? 8'h78 : 8'h6E;
      3'h3: return p ? 8'h73 : 8'h69;
      3'h4: return p ? 8'h6E : 8'h64;
      3'h5: return p ? 8'h69 : 8'h64;
      default: return 8'h64;
    endcase
  endfunction

  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);

  a_track_gate: assert property (luma_gain_mode_select != 3'h2 |=> tracking_speed == 2'h0)
    else $error("Tracking speed nonzero outside automatic mode.");
  a_track_pass: assert property (
    luma_gain_mode_select == 3'h2 |=> tracking_speed == $past(luma_gain_tracking_speed))
    else $error("Tracking speed not passed on in automatic mode.");
  a_gain_auto: assert property (
    luma_gain_mode_select == 3'h2 |=> applied_gain == $past(auto_gain))
    else $error("Applied gain does not follow automatic gain.");
  a_gain_freeze: assert property (luma_gain_mode_select == 3'h7 |=> $stable(applied_gain))
    else $error("Applied gain moved while frozen.");
  a_read_applied: assert property (rd_en && addr == 8'h30 |=> rd_data == $past(gain_lo))
    else $error("Gain low byte read is not the applied gain.");
  a_update_mode: assert property (
    gain_update |-> $past(luma_gain_mode_select) inside {3'h5, 3'h6})
    else $error("Gain update outside a measuring mode.");
  a_update_pulse: assert property (gain_update |=> !gain_update)
    else $error("Gain update longer than one cycle.");
  a_ire_table: assert property (!$past(rst) && $stable(is_pal)
    |-> max_ire_level == ire_ref(gain_ctrl.ire_code, is_pal))
    else $error("Maximum input level differs from its table.");
  a_avg_lines: assert property (
    avg_window |-> $past(line_num) >= 9'h021 && $past(line_num) <= 9'h136)
    else $error("Average window open outside lines 33 to 310.");
endmodule

bind luma_gain_hsync_position_regs luma_gain_chk u_luma_gain_chk (.core_clk, .rst, .addr,
  .rd_en, .rd_data, .luma_gain_mode_select, .luma_gain_tracking_speed, .auto_gain, .is_pal,
  .line_num, .applied_gain, .tracking_speed, .gain_update, .gain_ctrl, .max_ire_level,
  .avg_window);

// ### test/tb_luma_gain_hsync_position_regs.sv
// Self-checking bench for the luma gain and hsync position register bank.
// Assumes read data one cycle after the strobe and line starts at hsync_int falls.
`timescale 1ns/10ps
module tb_luma_gain_hsync_position_regs;
  import luma_gain_pkg::*;
  localparam logic [7:0] RST_RD [8] = '{8'h00, 8'h70, 8'h00, 8'hA0, 8'h0F, 8'h01, 8'h00, 8'h00};
  localparam logic [7:0] IRE_P [8] = '{8'h85, 8'h7D, 8'h78, 8'h73, 8'h6E, 8'h69, 8'h64, 8'h64};
  localparam logic [7:0] IRE_N [8] = '{8'h7A, 8'h73, 8'h6E, 8'h69, 8'h64, 8'h64, 8'h64, 8'h64};
  localparam logic [8:0] AV_LN [6] = '{9'h12C, 9'h137, 9'h12C, 9'h10E, 9'h020, 9'h021};
  logic core_clk, rst, wr_en, rd_en, is_pal, hsync_int, field_start, gain_update;
  logic avg_window, hsync_out, tracking_active;
  logic rd_pend = 1'b0;
  logic [7:0] addr, wr_data, rd_data, max_ire_level, w;
  logic [2:0] mode;
  logic [1:0] speed, tracking_speed;
  logic [3:0] gain_hi;
  logic [11:0] auto_gain, applied_gain;
  logic [8:0] line_num;
  logic [31:0] seed;
  gain_ctrl_t gain_ctrl;
  logic [7:0] exp_q[$];
  int fail_count, samples_checked, upd_cnt, r0, r1, n;

  luma_gain_hsync_position_regs u_luma_gain_hsync_position_regs (.core_clk, .rst, .addr,
    .wr_data, .wr_en, .rd_en, .rd_data, .luma_gain_mode_select(mode),
    .luma_gain_tracking_speed(speed), .luma_manual_gain_high(gain_hi), .auto_gain, .is_pal,
    .hsync_int, .field_start, .line_num, .applied_gain, .tracking_speed, .tracking_active,
    .gain_update, .gain_ctrl, .max_ire_level, .avg_window, .hsync_out);

  // Free-running 100 MHz clock.
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  function automatic logic [31:0] xs(input logic [31:0] x);
    x ^= x << 13;
    x ^= x >> 17;
    x ^= x << 5;
    return x;
  endfunction

  task automatic chk(input logic [11:0] seen, input logic [11:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("CHECK FAILED at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask

  // Strobes are released a whole cycle later, so a following call never overlaps.
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk);
    addr <= a;
    wr_data <= d;
    wr_en <= 1'b1;
    @(posedge core_clk);
    wr_en <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge core_clk);
    addr <= a;
    rd_en <= 1'b1;
    exp_q.push_back(e);
    @(posedge core_clk);
    rd_en <= 1'b0;
  endtask

  // One line: hsync_int low for n cycles, then a short settle.
  task automatic line(input int len);
    @(posedge core_clk);
    hsync_int <= 1'b0;
    repeat (len) @(posedge core_clk);
    hsync_int <= 1'b1;
    repeat (4) @(posedge core_clk);
  endtask

  // Offset of the pulse from the line start and its width, both bounded.
  task automatic hs(output int rise, output int wid);
    rise = 0;
    wid = 0;
    @(posedge core_clk);
    hsync_int <= 1'b0;
    while (hsync_out !== 1'b1 && rise < 600) begin
      @(posedge core_clk);
      rise++;
    end
    while (hsync_out === 1'b1 && wid < 600) begin
      @(posedge core_clk);
      wid++;
    end
    hsync_int <= 1'b1;
    repeat (4) @(posedge core_clk);
  endtask

  task automatic report_and_stop;
    if (fail_count == 0 && samples_checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // Read data first stands in the cycle after the strobe, so it is compared there.
  always @(posedge core_clk) begin
    if (rd_pend) chk({4'h0, rd_data}, {4'h0, exp_q.pop_front()});
    rd_pend <= rd_en;
    if (gain_update === 1'b1) upd_cnt++;
  end

  // Watchdog sized well above the fewer than a thousand cycles the sequence needs.
  initial begin
    repeat (30000) @(posedge core_clk);
    fail_count++;
    report_and_stop();
  end

  initial begin
    {rst, is_pal, hsync_int} = 3'b111;
    {wr_en, rd_en, field_start} = 3'h0;
    addr = 8'h00;
    wr_data = 8'h00;
    mode = 3'h0;
    speed = 2'h3;
    gain_hi = 4'h0;
    auto_gain = 12'h000;
    line_num = 9'h000;
    seed = 32'h18D5;
    repeat (20) @(posedge core_clk);
    rst <= 1'b0;
    for (int k = 0; k < 8; k++) rd(8'h30 + 8'(k), RST_RD[k]);
    wr(OFS_HS_BEGIN_LO, 8'h03);
    wr(OFS_HS_END_LO, 8'h07);
    gain_hi <= 4'hA;
    wr(OFS_MAN_GAIN_LO, 8'h5C);
    line(8);
    chk(applied_gain, 12'hA5C);
    rd(OFS_MAN_GAIN_LO, 8'h5C);
    wr(OFS_SHADOW_LO, 8'h34);
    wr(OFS_SHADOW_HI, 8'h83);
    rd(OFS_SHADOW_HI, 8'hF3);
    chk(applied_gain, 12'hA5C);
    line(8);
    chk(applied_gain, 12'h334);
    rd(OFS_SHADOW_LO, 8'h34);
    wr(OFS_SHADOW_HI, 8'h03);
    line(8);
    chk(applied_gain, 12'hA5C);
    for (int k = 0; k < 4; k++) begin
      seed = xs(seed);
      mode <= 3'h2;
      auto_gain <= seed[11:0];
      speed <= seed[13:12];
      repeat (2) @(posedge core_clk);
      chk(applied_gain, seed[11:0]);
      chk({10'h0, tracking_speed}, {10'h0, seed[13:12]});
      chk({11'h0, tracking_active}, 12'h001);
      rd(OFS_SHADOW_LO, seed[7:0]);
      rd(OFS_SHADOW_HI, {4'h7, seed[11:8]});
    end
    mode <= 3'h7;
    auto_gain <= ~seed[11:0];
    repeat (3) @(posedge core_clk);
    chk(applied_gain, seed[11:0]);
    chk({10'h0, tracking_speed}, 12'h000);
    chk({11'h0, tracking_active}, 12'h000);
    for (int k = 0; k < 16; k++) begin
      w = {1'b0, k[0], 1'b0, k[2:0], k[2], k[1]};
      is_pal <= k[3];
      wr(OFS_MISC, w);
      repeat (3) @(posedge core_clk);
      chk({6'h0, gain_ctrl}, {6'h0, k[1], k[2], k[2:0], k[0]});
      chk({4'h0, max_ire_level}, {4'h0, k[3] ? IRE_P[k[2:0]] : IRE_N[k[2:0]]});
      rd(OFS_MISC, w | 8'hA0);
    end
    mode <= 3'h5;
    wr(OFS_MISC, 8'h00);
    n = upd_cnt;
    line(8);
    chk(12'(upd_cnt - n), 12'h001);
    chk(applied_gain, ~seed[11:0]);
    wr(OFS_MISC, 8'h01);
    n = upd_cnt;
    line(8);
    chk(12'(upd_cnt - n), 12'h000);
    field_start <= 1'b1;
    @(posedge core_clk);
    field_start <= 1'b0;
    repeat (3) @(posedge core_clk);
    chk(12'(upd_cnt - n), 12'h001);
    mode <= 3'h6;
    for (int k = 0; k < 6; k++) begin
      wr(OFS_MISC, {6'h00, (k == 2 || k == 3), 1'b0});
      line_num <= AV_LN[k];
      repeat (3) @(posedge core_clk);
      chk({11'h0, avg_window}, {11'h0, (k == 0 || k == 3 || k == 5)});
    end
    mode <= 3'h4;
    hs(r0, n);
    chk(12'(n), 12'h004);
    wr(OFS_HS_HI, 8'h50);
    rd(OFS_HS_HI, 8'h5F);
    hs(r1, n);
    chk(12'(n), 12'h004);
    chk(12'(r1 - r0), 12'h100);
    chk(applied_gain, ~seed[11:0]);
    chk({11'h0, tracking_active}, 12'h000);
    repeat (4) @(posedge core_clk);
    report_and_stop();
  end
endmodule
